// file: common/adc_cfg_pkg.sv
// register map, field layouts, reset values and data-path constants of the converter config bank
package adc_cfg_pkg;

   localparam logic [12:0] ADDR_REFERENCE_SCALE = 13'h0008;
   localparam logic [12:0] ADDR_INPUT_BIAS      = 13'h0010;
   localparam logic [12:0] ADDR_OUTPUT_STANDARD = 13'h0011;
   localparam logic [12:0] ADDR_OUTPUT_CLOCK    = 13'h0012;
   localparam logic [12:0] ADDR_DIGITAL_OFFSET  = 13'h0013;
   localparam logic [12:0] ADDR_PATTERN_SELECT  = 13'h0014;
   localparam logic [12:0] ADDR_CUSTOM_HIGH     = 13'h0015;
   localparam logic [12:0] ADDR_CUSTOM_LOW      = 13'h0016;
   localparam logic [12:0] ADDR_RANGE_DETECT    = 13'h0017;
   localparam logic [12:0] ADDR_CMOS_DRIVE      = 13'h0020;
   localparam logic [12:0] ADDR_LVDS_CURRENT    = 13'h0021;
   localparam logic [12:0] ADDR_LVDS_TERM       = 13'h0022;

   localparam int INSTR_BITS  = 16;
   localparam int BYTE_BITS   = 8;
   localparam logic [1:0] COUNT_STREAM = 2'h3;

   localparam int RANGE_LATENCY_NORMAL = 14;
   localparam int RANGE_LATENCY_FAST   = 4;

   localparam logic [2:0] SCALE_RESERVED = 3'h7;
   localparam logic [1:0] BIAS_INVALID   = 2'h0;

   localparam logic [1:0] FORMAT_OFFSET_BINARY = 2'h0;
   localparam logic [1:0] FORMAT_TWOS          = 2'h1;
   localparam logic [1:0] FORMAT_GRAY          = 2'h2;

   localparam logic [2:0] PATTERN_OFF     = 3'h0;
   localparam logic [2:0] PATTERN_MID     = 3'h1;
   localparam logic [2:0] PATTERN_NEG_FS  = 3'h2;
   localparam logic [2:0] PATTERN_POS_FS  = 3'h3;
   localparam logic [2:0] PATTERN_TOGGLE  = 3'h4;
   localparam logic [2:0] PATTERN_CUSTOM  = 3'h5;
   localparam logic [2:0] PATTERN_ALT_ONE = 3'h6;
   localparam logic [2:0] PATTERN_ALT_TWO = 3'h7;

   localparam logic [9:0] WORD_MID     = 10'h200;
   localparam logic [9:0] WORD_NEG_FS  = 10'h000;
   localparam logic [9:0] WORD_POS_FS  = 10'h3ff;
   localparam logic [9:0] WORD_ALT_ONE = 10'h2aa;
   localparam logic [9:0] WORD_ALT_TWO = 10'h155;
   localparam logic [10:0] CODE_MAX    = 11'h3ff;

   typedef struct packed {
      logic       ref_scale_enable;
      logic [2:0] ref_scale_select;
      logic [1:0] buffer_bias_select;
      logic       lvds_mode;
      logic       output_tristate;
      logic       bit_order_reverse;
      logic [1:0] data_format;
      logic       valid_clock_invert;
      logic [2:0] valid_clock_phase;
      logic [5:0] code_offset;
      logic [2:0] pattern_select;
      logic [9:0] custom_pattern_word;
      logic       fast_range_enable;
      logic [2:0] fast_range_threshold;
      logic [1:0] valid_clock_drive;
      logic [1:0] sample_bus_drive;
      logic       valid_current_double;
      logic [1:0] valid_current_select;
      logic       sample_current_double;
      logic [1:0] sample_current_select;
      logic       byte_wise_order;
      logic [2:0] termination_select;
   } config_type;

   localparam config_type CONFIG_RESET = '0;

endpackage

// file: verilog/adc_output_config_registers.sv
// serially programmed configuration bank and output data path of the 10-bit converter
//
// Contract
// - Reference scale is applied only when enabled; code 111 is reserved.
// - Bias field decodes 01 medium, 10 low, 11 high; 00 invalid.
// - Output standard bit 4: 0 CMOS, 1 double-data-rate LVDS.
// - Output buffer bit 3: 0 drives data pins, 1 releases them.
// - Bus swap bit 2 reverses the output bit order.
// - Format field: 00 offset binary, 01 two's complement, 10 Gray, 11 offset binary.
// - Polarity bit 3 inverts the data-valid clock.
// - Phase field shifts the data-valid clock; 110 nominal, 111 delays. The phase field is only stored; o_valid_clock_out ignores it.
// - Signed 6-bit offset is added to every converted sample, saturating at 000 and 3ff; test patterns bypass it.
// - Three-bit field selects off, fixed, toggling, custom or alternating patterns.
// - Custom word: upper eight bits in one register, lower two in the next.
// - Fast range detection is enabled by bit 3.
// - Three-bit field sets fast detection threshold below full scale.
// - Two independent 2-bit CMOS drive fields, low to very high.
// - Valid-clock LVDS current from 2-bit field, doubled by its enable.
// - Data LVDS current has its own field and doubling enable.
// - DDR order bit: 0 even/odd bits per edge, 1 upper/lower halves.
// - Three-bit termination field applies to valid-clock and data buffers.
// - Range flag follows the sample by fourteen clocks, four when fast.
// - A selected test pattern replaces the converted sample.
// - Access: two instruction bytes then data bytes, most significant bit first.
// - Address advances after each data byte of a multi-byte access.
`timescale 1ns/1ps
module adc_output_config_registers (
   input  wire logic                     i_clk,          // sample clock
   input  wire logic                     i_rst_n,        // async reset, active low
   input  wire logic                     i_serial_clk,   // serial port clock
   input  wire logic                     i_select_n,     // serial port select, active low
   input  wire logic                     i_sdio_in,      // serial data pin, input side
   output logic                          o_sdio_out,     // serial data pin, output side
   output logic                          o_sdio_oe,      // serial data pin drive enable
   input  wire logic [9:0]               i_sample,       // core sample, offset binary
   input  wire logic                     i_range_raw,    // core over-range indication
   output logic [9:0]                    o_sample_bus,   // CMOS data pins
   output logic                          o_sample_oe,    // data pin drive enable
   output logic [4:0]                    o_ddr_rise,     // LVDS bits for rising edge
   output logic [4:0]                    o_ddr_fall,     // LVDS bits for falling edge
   output logic                          o_valid_clock_out, // data-valid clock level
   output logic                          o_range_exceeded_flag, // delayed range flag
   output adc_cfg_pkg::config_type       o_config        // settings for analog blocks
);
   import adc_cfg_pkg::*;

   typedef enum logic [1:0] {IDLE, INSTR, DATA, DONE} phase_type;

   typedef struct packed {
      config_type cfg;
      phase_type  phase;
      logic       sclk_prev;
      logic [4:0] bit_count;
      logic [7:0] shift_in;
      logic [7:0] shift_out;
      logic       read_op;
      logic [1:0] byte_code;
      logic [1:0] bytes_done;
      logic [12:0] addr;
      logic       sdio_out;
      logic       sdio_oe;
      logic       toggle;
      logic [RANGE_LATENCY_NORMAL-1:0] range_pipe;
      logic [9:0] sample_bus;
      logic       sample_oe;
      logic [4:0] ddr_rise;
      logic [4:0] ddr_fall;
      logic       valid_clock;
      logic       range_flag;
   } state_type;

   state_type state;
   state_type next_state;

   // register read image; unused bits are zero
   function automatic logic [7:0] read_reg(input config_type c, input logic [12:0] a);
      logic [7:0] d;
      d = 8'h00;
      if (a == ADDR_REFERENCE_SCALE) begin
         d = {4'h0, c.ref_scale_enable, c.ref_scale_select};
      end else if (a == ADDR_INPUT_BIAS) begin
         d = {6'h00, c.buffer_bias_select};
      end else if (a == ADDR_OUTPUT_STANDARD) begin
         d = {3'h0, c.lvds_mode, c.output_tristate, c.bit_order_reverse, c.data_format};
      end else if (a == ADDR_OUTPUT_CLOCK) begin
         d = {4'h0, c.valid_clock_invert, c.valid_clock_phase};
      end else if (a == ADDR_DIGITAL_OFFSET) begin
         d = {2'h0, c.code_offset};
      end else if (a == ADDR_PATTERN_SELECT) begin
         d = {5'h00, c.pattern_select};
      end else if (a == ADDR_CUSTOM_HIGH) begin
         d = c.custom_pattern_word[9:2];
      end else if (a == ADDR_CUSTOM_LOW) begin
         d = {c.custom_pattern_word[1:0], 6'h00};
      end else if (a == ADDR_RANGE_DETECT) begin
         d = {4'h0, c.fast_range_enable, c.fast_range_threshold};
      end else if (a == ADDR_CMOS_DRIVE) begin
         d = {4'h0, c.valid_clock_drive, c.sample_bus_drive};
      end else if (a == ADDR_LVDS_CURRENT) begin
         d = {2'h0, c.valid_current_double, c.valid_current_select,
              c.sample_current_double, c.sample_current_select};
      end else if (a == ADDR_LVDS_TERM) begin
         d = {4'h0, c.byte_wise_order, c.termination_select};
      end
      return d;
   endfunction

   // register write; unused bits are dropped
   function automatic config_type write_reg(input config_type c, input logic [12:0] a,
                                            input logic [7:0] d);
      config_type n;
      n = c;
      if (a == ADDR_REFERENCE_SCALE) begin
         n.ref_scale_enable = d[3];
         n.ref_scale_select = d[2:0];
      end else if (a == ADDR_INPUT_BIAS) begin
         n.buffer_bias_select = d[1:0];
      end else if (a == ADDR_OUTPUT_STANDARD) begin
         n.lvds_mode = d[4];
         n.output_tristate = d[3];
         n.bit_order_reverse = d[2];
         n.data_format = d[1:0];
      end else if (a == ADDR_OUTPUT_CLOCK) begin
         n.valid_clock_invert = d[3];
         n.valid_clock_phase = d[2:0];
      end else if (a == ADDR_DIGITAL_OFFSET) begin
         n.code_offset = d[5:0];
      end else if (a == ADDR_PATTERN_SELECT) begin
         n.pattern_select = d[2:0];
      end else if (a == ADDR_CUSTOM_HIGH) begin
         n.custom_pattern_word[9:2] = d;
      end else if (a == ADDR_CUSTOM_LOW) begin
         n.custom_pattern_word[1:0] = d[7:6];
      end else if (a == ADDR_RANGE_DETECT) begin
         n.fast_range_enable = d[3];
         n.fast_range_threshold = d[2:0];
      end else if (a == ADDR_CMOS_DRIVE) begin
         n.valid_clock_drive = d[3:2];
         n.sample_bus_drive = d[1:0];
      end else if (a == ADDR_LVDS_CURRENT) begin
         n.valid_current_double = d[5];
         n.valid_current_select = d[4:3];
         n.sample_current_double = d[2];
         n.sample_current_select = d[1:0];
      end else if (a == ADDR_LVDS_TERM) begin
         n.byte_wise_order = d[3];
         n.termination_select = d[2:0];
      end
      return n;
   endfunction

   logic        sclk_rise;
   logic        sclk_fall;
   logic [10:0] offset_sum;
   logic [9:0]  code;
   logic [9:0]  formatted;
   logic [9:0]  word;
   logic [9:0]  ordered;
   logic [7:0]  byte_in;

   always_comb begin
      next_state = state;
      sclk_rise = i_serial_clk & ~state.sclk_prev;
      sclk_fall = ~i_serial_clk & state.sclk_prev;
      byte_in = {state.shift_in[6:0], i_sdio_in};
      next_state.sclk_prev = i_serial_clk;

      // serial port
      if (i_select_n) begin
         next_state.phase = IDLE;
         next_state.sdio_oe = 1'b0;
         next_state.bit_count = '0;
      end else begin
         if (state.phase == IDLE) begin
            next_state.phase = INSTR;
         end
         if (sclk_rise) begin
            next_state.shift_in = byte_in;
            next_state.bit_count = state.bit_count + 5'h01;
            case (next_state.phase)
               INSTR: begin
                  if (state.bit_count == 5'(BYTE_BITS - 1)) begin
                     next_state.read_op = byte_in[7];
                     next_state.byte_code = byte_in[6:5];
                     next_state.addr[12:8] = byte_in[4:0];
                  end
                  if (state.bit_count == 5'(INSTR_BITS - 1)) begin
                     next_state.addr[7:0] = byte_in;
                     next_state.phase = DATA;
                     next_state.bit_count = '0;
                     next_state.bytes_done = '0;
                     next_state.shift_out = read_reg(state.cfg, {state.addr[12:8], byte_in});
                  end
               end
               DATA: begin
                  if (state.bit_count == 5'(BYTE_BITS - 1)) begin
                     next_state.bit_count = '0;
                     if (!state.read_op) begin
                        next_state.cfg = write_reg(state.cfg, state.addr, byte_in);
                     end
                     next_state.addr = state.addr + 13'h0001;
                     next_state.shift_out = read_reg(state.cfg, state.addr + 13'h0001);
                     next_state.bytes_done = state.bytes_done + 2'h1;
                     if (state.byte_code != COUNT_STREAM &&
                         state.bytes_done == state.byte_code) begin
                        next_state.phase = DONE;
                     end
                  end
               end
               default: begin
               end
            endcase
         end
         // read data changes on the falling serial clock edge, sampled on the rising one
         if (sclk_fall && state.phase == DATA && state.read_op) begin
            next_state.sdio_oe = 1'b1;
            next_state.sdio_out = state.shift_out[7];
            next_state.shift_out = {state.shift_out[6:0], 1'b0};
         end
         if (state.phase == DONE) begin
            next_state.sdio_oe = 1'b0;
         end
      end

      // data path
      next_state.toggle = ~state.toggle;
      offset_sum = {1'b0, i_sample} + {{5{state.cfg.code_offset[5]}}, state.cfg.code_offset};
      if (offset_sum[10] && state.cfg.code_offset[5]) begin
         code = WORD_NEG_FS;
      end else if (offset_sum > CODE_MAX) begin
         code = WORD_POS_FS;
      end else begin
         code = offset_sum[9:0];
      end
      case (state.cfg.data_format)
         FORMAT_TWOS: formatted = {~code[9], code[8:0]};
         FORMAT_GRAY: formatted = code ^ (code >> 1);
         default:     formatted = code;
      endcase
      case (state.cfg.pattern_select)
         PATTERN_MID:     word = WORD_MID;
         PATTERN_NEG_FS:  word = WORD_NEG_FS;
         PATTERN_POS_FS:  word = WORD_POS_FS;
         PATTERN_TOGGLE:  word = state.toggle ? WORD_POS_FS : WORD_NEG_FS;
         PATTERN_CUSTOM:  word = state.cfg.custom_pattern_word;
         PATTERN_ALT_ONE: word = WORD_ALT_ONE;
         PATTERN_ALT_TWO: word = WORD_ALT_TWO;
         default:         word = formatted;
      endcase
      for (int i = 0; i < 10; i++) begin
         ordered[i] = state.cfg.bit_order_reverse ? word[9 - i] : word[i];
      end
      next_state.sample_oe = ~state.cfg.output_tristate;
      if (state.cfg.lvds_mode) begin
         next_state.sample_bus = '0;
         if (state.cfg.byte_wise_order) begin
            next_state.ddr_rise = ordered[9:5];
            next_state.ddr_fall = ordered[4:0];
         end else begin
            next_state.ddr_rise = {ordered[8], ordered[6], ordered[4], ordered[2], ordered[0]};
            next_state.ddr_fall = {ordered[9], ordered[7], ordered[5], ordered[3], ordered[1]};
         end
      end else begin
         next_state.sample_bus = ordered;
         next_state.ddr_rise = '0;
         next_state.ddr_fall = '0;
      end
      next_state.valid_clock = state.toggle ^ state.cfg.valid_clock_invert;

      next_state.range_pipe = {state.range_pipe[RANGE_LATENCY_NORMAL-2:0], i_range_raw};
      next_state.range_flag = state.cfg.fast_range_enable ?
                              state.range_pipe[RANGE_LATENCY_FAST-2] :
                              state.range_pipe[RANGE_LATENCY_NORMAL-2];
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= '{cfg: CONFIG_RESET, phase: IDLE, default: '0};
      end else begin
         state <= next_state;
      end
   end

   assign o_sdio_out            = state.sdio_out;
   assign o_sdio_oe             = state.sdio_oe;
   assign o_sample_bus          = state.sample_bus;
   assign o_sample_oe           = state.sample_oe;
   assign o_ddr_rise            = state.ddr_rise;
   assign o_ddr_fall            = state.ddr_fall;
   assign o_valid_clock_out     = state.valid_clock;
   assign o_range_exceeded_flag = state.range_flag;
   assign o_config              = state.cfg;

endmodule // adc_output_config_registers

// file: testbench/adc_cfg_chk.sv
// port checker of the converter configuration bank
`timescale 1ns/1ps
module adc_cfg_chk
   import adc_cfg_pkg::*;
(
   input wire logic                     i_clk,                 // clock
   input wire logic                     i_rst_n,               // reset, active low
   input wire logic                     i_serial_clk,          // serial clock
   input wire logic                     i_select_n,            // select, active low
   input wire logic                     i_sdio_in,             // serial data in
   input wire logic                     o_sdio_out,            // serial data out
   input wire logic                     o_sdio_oe,             // serial drive enable
   input wire logic [9:0]               i_sample,              // core sample
   input wire logic                     i_range_raw,           // core over-range
   input wire logic [9:0]               o_sample_bus,          // cmos data
   input wire logic                     o_sample_oe,           // data enable
   input wire logic [4:0]               o_ddr_rise,            // rising half
   input wire logic [4:0]               o_ddr_fall,            // falling half
   input wire logic                     o_valid_clock_out,     // valid clock
   input wire logic                     o_range_exceeded_flag, // range flag
   input wire adc_cfg_pkg::config_type  o_config               // settings
);
   logic [4:0] calm;
   config_type last;
   wire quiet = (calm >= 5'h2) && (o_config == last);
   wire settled = (calm >= 5'h10) && (o_config == last);
   wire plain = quiet && o_config.pattern_select == PATTERN_OFF && !o_config.lvds_mode
                && !o_config.bit_order_reverse && o_config.code_offset == 6'h0;
   // cycles since settings last changed, saturating
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         calm <= 5'h0;
         last <= '0;
      end else begin
         last <= o_config;
         calm <= (o_config != last) ? 5'h0 : ((calm == 5'h1f) ? calm : calm + 5'h1);
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   a_cmos_ddr_idle: assert property (quiet && !o_config.lvds_mode |->
      o_ddr_rise == 5'h0 && o_ddr_fall == 5'h0) else $error("ddr active in cmos mode");
   a_lvds_bus_idle: assert property (quiet && o_config.lvds_mode |->
      o_sample_bus == 10'h0) else $error("cmos bus active in lvds mode");
   a_pin_enable: assert property (quiet |-> o_sample_oe == !o_config.output_tristate)
      else $error("data enable disagrees with tristate bit");
   a_range_normal: assert property (settled && !o_config.fast_range_enable |->
      o_range_exceeded_flag == $past(i_range_raw, 14)) else $error("normal range delay");
   a_range_fast: assert property (settled && o_config.fast_range_enable |->
      o_range_exceeded_flag == $past(i_range_raw, 4)) else $error("fast range delay");
   a_twos_format: assert property (plain && o_config.data_format == FORMAT_TWOS |->
      o_sample_bus == ($past(i_sample) ^ 10'h200)) else $error("twos complement code");
   a_gray_format: assert property (plain && o_config.data_format == FORMAT_GRAY |->
      o_sample_bus == ($past(i_sample) ^ ($past(i_sample) >> 1))) else $error("gray code");
   a_pattern_mid: assert property (quiet && o_config.pattern_select == PATTERN_MID
      && !o_config.lvds_mode && !o_config.bit_order_reverse |-> o_sample_bus == 10'h200)
      else $error("mid scale pattern");
   a_valid_toggle: assert property (quiet |-> o_valid_clock_out != $past(o_valid_clock_out))
      else $error("valid clock stalled");
   a_sdio_released: assert property (i_select_n [*3] |-> !o_sdio_oe)
      else $error("serial data driven while deselected");
   c_fast_flag: cover property (o_config.fast_range_enable && o_range_exceeded_flag);
   c_read_phase: cover property (o_sdio_oe);
   c_byte_wise: cover property (o_config.lvds_mode && o_config.byte_wise_order);
endmodule // adc_cfg_chk
bind adc_output_config_registers adc_cfg_chk chk (.*);

// file: testbench/adc_cfg_host.sv
// behavioural host driving the three-wire configuration port
`timescale 1ns/1ps
module adc_cfg_host (
   input  wire logic i_clk,        // sample clock
   input  wire logic i_sdio_out,   // device read data
   input  wire logic i_sdio_oe,    // device drives data line
   output logic      o_serial_clk, // serial clock, idle low
   output logic      o_select_n,   // select, active low
   output logic      o_sdio_in     // host data to device
);
   initial begin
      o_serial_clk = 1'b0;
      o_select_n   = 1'b1;
      o_sdio_in    = 1'b0;
   end
   // one bit: three clocks low, sample, three clocks high
   task automatic bit_io(input logic b, output logic r);
      o_serial_clk <= 1'b0;
      o_sdio_in    <= b;
      repeat (3) @(posedge i_clk);
      r = i_sdio_oe ? i_sdio_out : 1'bx;
      o_serial_clk <= 1'b1;
      repeat (3) @(posedge i_clk);
   endtask
   task automatic xfer(input logic rw, input logic [12:0] addr, input int n,
                       inout logic [7:0] d [4]);
      logic [15:0] ins;
      logic        r;
      ins = {rw, 2'(n - 1), addr};
      @(posedge i_clk);
      o_select_n <= 1'b0;
      @(posedge i_clk);
      for (int i = 15; i >= 0; i--) bit_io(ins[i], r);
      for (int k = 0; k < n; k++) begin
         for (int i = 7; i >= 0; i--) begin
            // released line toggles so a stale level never reads back
            bit_io(rw ? ~o_sdio_in : d[k][i], r);
            if (rw) d[k][i] = r;
         end
      end
      o_select_n <= 1'b1;
      @(posedge i_clk);
      o_serial_clk <= 1'b0;
      repeat (3) @(posedge i_clk);
   endtask
endmodule // adc_cfg_host

// file: testbench/adc_output_config_registers_tb.sv
// self-checking bench of the converter configuration bank
`timescale 1ns/1ps
module adc_output_config_registers_tb;
   import adc_cfg_pkg::*;
   logic       i_clk = 1'b0, i_rst_n = 1'b0, i_range_raw = 1'b0;
   logic [9:0] i_sample = 10'h0ab;
   wire logic  sclk, sel_n, sdi, sdo, sdo_oe, s_oe, vclk, flag;
   wire logic [9:0] bus;
   wire logic [4:0] rise, fall;
   config_type cfg;
   int         failures = 0, checks = 0, cycles = 0;
   logic [7:0] d [4];
   always #2 i_clk = ~i_clk;
   adc_output_config_registers dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_serial_clk(sclk),
      .i_select_n(sel_n), .i_sdio_in(sdi), .o_sdio_out(sdo), .o_sdio_oe(sdo_oe),
      .i_sample(i_sample), .i_range_raw(i_range_raw), .o_sample_bus(bus), .o_sample_oe(s_oe),
      .o_ddr_rise(rise), .o_ddr_fall(fall), .o_valid_clock_out(vclk),
      .o_range_exceeded_flag(flag), .o_config(cfg));
   adc_cfg_host host (.i_clk(i_clk), .i_sdio_out(sdo), .i_sdio_oe(sdo_oe),
      .o_serial_clk(sclk), .o_select_n(sel_n), .o_sdio_in(sdi));
   task automatic stop_test();
      $display("failures=%0d checks=%0d", failures, checks);
      if (failures == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("Error %0t reg got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic check_bus(input logic [9:0] got, input logic [9:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("Error %0t bus got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [12:0] a, input logic [7:0] v);
      d[0] = v;
      host.xfer(1'b0, a, 1, d);
      repeat (2) @(posedge i_clk);
      #1;
   endtask
   task automatic rd(input logic [12:0] a, input logic [7:0] exp);
      host.xfer(1'b1, a, 1, d);
      check_reg(d[0], exp);
   endtask
   task automatic samp(input logic [9:0] v);
      @(posedge i_clk);
      i_sample <= v;
      repeat (2) @(posedge i_clk);
      #1;
   endtask
   task automatic test_registers();
      logic [12:0] a [12];
      logic [7:0]  m [12];
      a = '{ADDR_REFERENCE_SCALE, ADDR_INPUT_BIAS, ADDR_OUTPUT_STANDARD, ADDR_OUTPUT_CLOCK,
            ADDR_DIGITAL_OFFSET, ADDR_PATTERN_SELECT, ADDR_CUSTOM_HIGH, ADDR_CUSTOM_LOW,
            ADDR_RANGE_DETECT, ADDR_CMOS_DRIVE, ADDR_LVDS_CURRENT, ADDR_LVDS_TERM};
      m = '{8'h0e, 8'h03, 8'h1f, 8'h0f, 8'h3f, 8'h07, 8'hff, 8'hc0, 8'h0f, 8'h0f, 8'h3f, 8'h0f};
      for (int i = 0; i < 12; i++) begin
         rd(a[i], 8'h00);
         wr(a[i], (i == 0) ? 8'hfe : 8'hff);
         rd(a[i], m[i]);
         wr(a[i], 8'h00);
      end
      wr(13'h0030, 8'hff);
      rd(13'h0030, 8'h00);
   endtask
   task automatic test_burst();
      d = '{8'ha5, 8'hc0, 8'h0d, 8'h00};
      host.xfer(1'b0, ADDR_CUSTOM_HIGH, 3, d);
      check_bus(cfg.custom_pattern_word, 10'h297);
      check_reg({4'h0, cfg.fast_range_enable, cfg.fast_range_threshold}, 8'h0d);
      host.xfer(1'b1, ADDR_CUSTOM_HIGH, 3, d);
      check_reg(d[1], 8'hc0);
      check_reg(d[2], 8'h0d);
      wr(ADDR_PATTERN_SELECT, 8'h05);
      check_bus(bus, 10'h297);
      wr(ADDR_OUTPUT_STANDARD, 8'h04);
      check_bus(bus, 10'h3a5);
      wr(ADDR_OUTPUT_STANDARD, 8'h10);
      check_bus({rise, fall}, 10'h0f9);
      check_bus(bus, 10'h000);
      wr(ADDR_LVDS_TERM, 8'h08);
      check_bus({rise, fall}, 10'h297);
      wr(ADDR_OUTPUT_STANDARD, 8'h08);
      check_reg({7'h0, s_oe}, 8'h00);
      wr(ADDR_OUTPUT_STANDARD, 8'h00);
      check_reg({7'h0, s_oe}, 8'h01);
      wr(ADDR_LVDS_TERM, 8'h00);
   endtask
   task automatic test_patterns();
      logic [9:0] w [8];
      logic [9:0] t;
      w = '{10'h0, 10'h200, 10'h000, 10'h3ff, 10'h0, 10'h0, WORD_ALT_ONE, WORD_ALT_TWO};
      for (int i = 1; i < 8; i++) if (i != 4 && i != 5) begin
         wr(ADDR_PATTERN_SELECT, 8'(i));
         check_bus(bus, w[i]);
      end
      wr(ADDR_PATTERN_SELECT, 8'h04);
      t = bus;
      @(posedge i_clk);
      #1;
      check_bus(bus ^ t, 10'h3ff);
      check_bus((t == 10'h0) ? 10'h3ff : t, 10'h3ff);
      // toggle pattern and valid clock run from one toggle, so their relation shows the polarity
      check_bus({9'h0, vclk ^ bus[0]}, 10'h000);
      wr(ADDR_OUTPUT_CLOCK, 8'h08);
      check_bus({9'h0, vclk ^ bus[0]}, 10'h001);
      wr(ADDR_OUTPUT_CLOCK, 8'h00);
      wr(ADDR_PATTERN_SELECT, 8'h00);
   endtask
   task automatic test_format();
      logic [9:0] e [4];
      e = '{10'h123, 10'h323, 10'h1b2, 10'h123};
      samp(10'h123);
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_OUTPUT_STANDARD, 8'(i));
         check_bus(bus, e[i]);
      end
      wr(ADDR_OUTPUT_STANDARD, 8'h00);
      wr(ADDR_DIGITAL_OFFSET, 8'h1f);
      check_bus(bus, 10'h142);
      samp(10'h3f0);
      check_bus(bus, 10'h3ff);
      wr(ADDR_DIGITAL_OFFSET, 8'h20);
      check_bus(bus, 10'h3d0);
      samp(10'h010);
      check_bus(bus, 10'h000);
      wr(ADDR_DIGITAL_OFFSET, 8'h00);
   endtask
   task automatic range_wait(input logic fast, input int exp);
      int n;
      wr(ADDR_RANGE_DETECT, {4'h0, fast, 3'h0});
      repeat (16) @(posedge i_clk);
      i_range_raw <= 1'b1;
      @(posedge i_clk);
      i_range_raw <= 1'b0;
      #1;
      n = 1;
      while (flag !== 1'b1 && n < 40) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      check_reg(8'(n), 8'(exp));
   endtask
   initial begin
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'b1;
      test_registers();
      test_burst();
      test_patterns();
      test_format();
      range_wait(1'b0, 14);
      range_wait(1'b1, 4);
      stop_test();
   end
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         failures++;
         stop_test();
      end
   end
endmodule // adc_output_config_registers_tb
